// ### pkg/acpg_pkg.sv
// Constants and types for the channel power gating block.
// Assumes a single 125 MHz clock domain and a synchronous reset.
package acpg_pkg;

  localparam int          NUM_CH        = 4;              // Converter channels
  localparam int          DATA_W        = 24;             // Conversion word width
  localparam int          PHASE_W       = 12;             // Phase delay width
  localparam int          SETTLE_W      = 16;             // Settle counter width
  localparam logic [3:0]  OFF_ALL       = 4'hf;           // Every channel off
  localparam logic [3:0]  OFF_RESET     = 4'hf;           // Channels off after reset
  localparam logic        EXT_RESET     = 1'h0;           // Ext selects after reset
  localparam logic [11:0] PHASE_RESET   = 12'h000;        // Phase counter after reset
  localparam logic [15:0] SETTLE_RESET  = 16'h0000;       // Settle counter after reset

  // Per-channel run state
  typedef enum logic [1:0] {
    ACPG_OFF,
    ACPG_SETTLE,
    ACPG_RUN
  } acpg_ch_state_t;

endpackage

// ### tb/acpg_host_model.sv
// Host model: holds the power configuration word the bench writes.
// Assumes writes arrive just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module acpg_host_model
(
  input  wire logic       clock,                // System clock
  input  wire logic       reset,                // Sync reset
  input  wire logic       wr,                   // Write strobe
  input  wire logic [5:0] wr_data,              // {ref, clk, off}
  output logic      [3:0] channel_off,          // Shutdown bits
  output logic            ext_reference_select, // Ext reference
  output logic            ext_clock_select      // Ext clock
);
  // Word stays until rewritten
  always_ff @(posedge clock)
  begin
    if (reset)
      {ext_reference_select, ext_clock_select, channel_off} <= 6'h0f;
    else if (wr)
      {ext_reference_select, ext_clock_select, channel_off} <= wr_data;
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Bench for the channel power gate, driven through the host model.
// Assumes a 125 MHz clock and inputs moved 1 ns after each edge.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import acpg_pkg::*;
  logic               clock, reset, wr;            // Clock, reset, strobe
  logic [5:0]         wr_data;                     // Config word
  logic [3:0]         channel_off, data_ready, channel_enable, sample_clock_enable;
  logic               ext_reference_select, ext_clock_select, core_clock_enable;
  logic               reference_enable, supply_monitor_enable, serial_port_enable, full_shutdown;
  logic [PHASE_W-1:0] phase_delay [NUM_CH];        // Per-channel phase
  logic [DATA_W-1:0]  raw_data [NUM_CH];           // Converter words
  logic [DATA_W-1:0]  conv_data [NUM_CH];          // Gated words
  int                 errors, n_checks, cyc, t0;   // Counters
  // ----------------
  // Instances
  // ----------------
  acpg_host_model acpg_host_model_inst (.clock(clock), .reset(reset), .wr(wr), .wr_data(wr_data),
    .channel_off(channel_off), .ext_reference_select(ext_reference_select),
    .ext_clock_select(ext_clock_select));
  acpg_power_gate acpg_power_gate_inst (.clock(clock), .reset(reset), .channel_off(channel_off),
    .ext_reference_select(ext_reference_select), .ext_clock_select(ext_clock_select),
    .phase_delay(phase_delay), .frame_period(12'h00f), .settle_cycles(16'h0001),
    .raw_data(raw_data), .conv_data(conv_data), .data_ready(data_ready),
    .channel_enable(channel_enable), .sample_clock_enable(sample_clock_enable),
    .core_clock_enable(core_clock_enable), .reference_enable(reference_enable),
    .supply_monitor_enable(supply_monitor_enable), .serial_port_enable(serial_port_enable),
    .full_shutdown(full_shutdown));
  // Clock source
  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  // Cycle count and hang limit
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      errors++;
      stop_test;
    end
  end
  // Compare and count
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // One host write, then the answer cycle
  task automatic cfg(input logic [5:0] w);
  begin
    wr = 1'h1;
    wr_data = w;
    @(posedge clock) #1;
    wr = 1'h0;
    @(posedge clock) #1;
  end
  endtask
  // Bounded wait for a ready pulse on channel n
  task automatic wait_rdy(input int n);
    int k;
  begin
    for (k = 0; k < 100; k++)
    begin
      @(posedge clock) #1;
      chk(data_ready & ~channel_enable, 4'h0);
      if (data_ready[n] === 1'h1)
        break;
    end
    chk(data_ready[n], 1'h1);
    chk(conv_data[n], raw_data[n]);
  end
  endtask
  // Verdict and end of run
  task automatic stop_test;
  begin
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Main sequence
  initial
  begin
    reset = 1'h1;
    wr = 1'h0;
    wr_data = 6'h0;
    for (int n = 0; n < NUM_CH; n++)
    begin
      phase_delay[n] = 12'(n * 3);
      raw_data[n] = 24'h5a0000 + 24'(n);
    end
    repeat (2) @(posedge clock);
    #1 reset = 1'h0;
    chk({channel_enable, reference_enable, supply_monitor_enable, serial_port_enable}, 7'h07);
    // Each channel alone: on, data, off
    for (int n = 0; n < NUM_CH; n++)
    begin
      cfg({2'h0, ~(4'h1 << n)});
      chk(channel_enable, 4'h1 << n);
      chk(core_clock_enable, 1'h1);
      wait_rdy(n);
      cfg(6'h0f);
      chk({core_clock_enable, sample_clock_enable}, 5'h00);
      chk(conv_data[n], 24'h0);
    end
    // Channel 1 rejoins a running channel 0, twice
    cfg(6'h0e);
    wait_rdy(0);
    t0 = cyc;
    repeat (2)
    begin
      cfg(6'h0c);
      wait_rdy(1);
      chk(24'((cyc - t0) % 16), 24'h3);
      cfg(6'h0e);
      chk(core_clock_enable, 1'h1);
      wait_rdy(0);
    end
    // Full shutdown and each way out
    for (int k = 0; k < 6; k++)
    begin
      cfg(6'h3f);
      chk({full_shutdown, channel_enable}, 5'h10);
      chk({reference_enable, supply_monitor_enable, core_clock_enable, sample_clock_enable,
           serial_port_enable}, 8'h01);
      cfg(6'h3f & ~(6'h1 << k));
      chk({full_shutdown, supply_monitor_enable, reference_enable}, 3'h3);
    end
    stop_test;
  end
endmodule
`default_nettype wire

// ### verilog/acpg_power_gate.sv
// Power-mode control for four converter channels.
// Assumes config bits come from the register file on the same clock.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Returning channel keeps its prior phase delay
// - Rejoining channel realigns to running channels
// - One channel off keeps shared clock
// - Returning channel resyncs to running clock itself
// - All off stops sampling and core clock
// - Any channel on restarts clock distribution
// - Full shutdown: all off, both ext selects
// - Full shutdown disables supply monitors, all clocks
// - Full shutdown: channels off, reference off
// - Full shutdown leaves configuration untouched
// - Serial port stays alive in full shutdown
// - Clearing any such bit reenables monitors
// - Full shutdown stops input sampling clocks
// - Channel on: biases, clock, logic; settle first
// - Off channel outputs zero, no ready pulses
// - Channels independent; config never modified
module acpg_power_gate
  import acpg_pkg::*;
(
  input  wire logic                           clock,            // 125 MHz clock
  input  wire logic                           reset,            // Sync reset, active high
  input  wire logic [acpg_pkg::NUM_CH-1:0]    channel_off,      // Per-channel shutdown bits
  input  wire logic                           ext_reference_select, // External reference chosen
  input  wire logic                           ext_clock_select, // External clock chosen
  input  wire logic [acpg_pkg::PHASE_W-1:0]   phase_delay [acpg_pkg::NUM_CH], // Phase per channel
  input  wire logic [acpg_pkg::PHASE_W-1:0]   frame_period,     // Frame length in cycles minus one
  input  wire logic [acpg_pkg::SETTLE_W-1:0]  settle_cycles,    // Filter settling frames
  input  wire logic [acpg_pkg::DATA_W-1:0]    raw_data [acpg_pkg::NUM_CH], // Converter results
  output logic      [acpg_pkg::DATA_W-1:0]    conv_data [acpg_pkg::NUM_CH], // Gated results
  output logic      [acpg_pkg::NUM_CH-1:0]    data_ready,       // Ready pulses
  output logic      [acpg_pkg::NUM_CH-1:0]    channel_enable,   // Bias, clock, logic enable
  output logic      [acpg_pkg::NUM_CH-1:0]    sample_clock_enable, // Input sampling clock gate
  output logic                                core_clock_enable,   // Digital core clock gate
  output logic                                reference_enable,    // Internal reference on
  output logic                                supply_monitor_enable, // Supply POR monitors on
  output logic                                serial_port_enable,  // Serial port alive
  output logic                                full_shutdown        // Full shutdown active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    acpg_ch_state_t [NUM_CH-1:0]               st;      // Channel states
    logic [NUM_CH-1:0][SETTLE_W-1:0]           settle;  // Settle frame counts
    logic [PHASE_W-1:0]                        phase;   // Shared frame phase
    logic [NUM_CH-1:0]                         rdy;     // Registered ready
    logic [NUM_CH-1:0][DATA_W-1:0]             dat;     // Registered data
    logic                                      core_en; // Core clock gate
    logic                                      fsd;     // Full shutdown
  } acpg_state_t;

  acpg_state_t s;       // Current state
  acpg_state_t next_s;  // Next state

  // Frame edge for one channel at its phase offset
  function automatic logic at_phase(input logic [PHASE_W-1:0] ph,
                                    input logic [PHASE_W-1:0] cnt);
    at_phase = (cnt == ph);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rdy = '0;
    // Full shutdown decode; clears as soon as any bit drops
    next_s.fsd = (channel_off == OFF_ALL) && ext_reference_select && ext_clock_select;
    // Full shutdown only gates enables; no configuration state is cleared
    // Core clock runs while any channel is on
    next_s.core_en = (channel_off != OFF_ALL);
    // Shared phase counter keeps running while any channel is on
    if (channel_off == OFF_ALL)
    begin
      next_s.phase = s.phase; // Frozen, clock not distributed
    end
    else if (s.phase >= frame_period)
    begin
      next_s.phase = '0;
    end
    else
    begin
      next_s.phase = s.phase + 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      unique case (s.st[i])
        ACPG_OFF:
        begin
          next_s.dat[i] = '0;
          if (!channel_off[i]) // Bit i owns channel i
          begin
            next_s.st[i] = ACPG_SETTLE;
            next_s.settle[i] = SETTLE_RESET;
          end
        end
        ACPG_SETTLE:
        begin
          if (channel_off[i])
          begin
            next_s.st[i] = ACPG_OFF;
          end
          else if (at_phase(phase_delay[i], s.phase)) // Aligned to shared phase
          begin
            if (s.settle[i] >= settle_cycles)
            begin
              next_s.st[i] = ACPG_RUN;
            end
            else
            begin
              next_s.settle[i] = s.settle[i] + 1'b1;
            end
          end
        end
        ACPG_RUN:
        begin
          if (channel_off[i])
          begin
            next_s.st[i] = ACPG_OFF;
            next_s.dat[i] = '0;
          end
          else if (at_phase(phase_delay[i], s.phase))
          begin
            next_s.rdy[i] = 1'b1; // Ready on realigned timing
            next_s.dat[i] = raw_data[i];
          end
        end
        default:
        begin
          next_s.st[i] = ACPG_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s.st      <= '{default: ACPG_OFF};
      s.settle  <= '0;
      s.phase   <= PHASE_RESET;
      s.rdy     <= '0;
      s.dat     <= '0;
      s.core_en <= 1'b0;
      s.fsd     <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign conv_data[g] = s.dat[g];
      assign channel_enable[g] = (s.st[g] != ACPG_OFF);
      // Sampling clock only while core clock runs
      assign sample_clock_enable[g] = s.core_en && !s.fsd;
    end
  endgenerate

  assign data_ready            = s.rdy;
  assign core_clock_enable     = s.core_en && !s.fsd;
  assign reference_enable      = !s.fsd;
  assign supply_monitor_enable = !s.fsd;
  assign serial_port_enable    = 1'b1;           // Never gated
  assign full_shutdown         = s.fsd;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_full_entry: assert property (@(posedge clock) disable iff (reset)
    ((channel_off == OFF_ALL) && ext_reference_select && ext_clock_select) |=> full_shutdown)
    else $error("full shutdown not entered");

  a_monitor_back: assert property (@(posedge clock) disable iff (reset)
    (full_shutdown && !((channel_off == OFF_ALL) && ext_reference_select && ext_clock_select))
    |=> supply_monitor_enable)
    else $error("monitors not restored");

  a_full_gates: assert property (@(posedge clock) disable iff (reset)
    full_shutdown |-> !core_clock_enable && !supply_monitor_enable && !reference_enable)
    else $error("full shutdown leaves something on");

  a_off_zero: assert property (@(posedge clock) disable iff (reset)
    (channel_off[0] && !channel_enable[0]) |=> (conv_data[0] == '0) && !data_ready[0])
    else $error("off channel emits data");

  a_clock_stop: assert property (@(posedge clock) disable iff (reset)
    (channel_off == OFF_ALL) |=> !core_clock_enable && (sample_clock_enable == '0))
    else $error("clock runs with all off");

  a_clock_restart: assert property (@(posedge clock) disable iff (reset)
    ($past(channel_off) == OFF_ALL && channel_off != OFF_ALL) |=> core_clock_enable)
    else $error("clock not restarted");

  a_shared_clock: assert property (@(posedge clock) disable iff (reset)
    ($rose(channel_off[1]) && channel_off != OFF_ALL) |=> core_clock_enable)
    else $error("shared clock stopped");

  a_ready_phase: assert property (@(posedge clock) disable iff (reset)
    data_ready[0] |-> $past(s.phase) == $past(phase_delay[0]))
    else $error("ready off phase");

  a_chan_enable: assert property (@(posedge clock) disable iff (reset)
    (!channel_off[2] && !channel_enable[2]) |=> channel_enable[2])
    else $error("channel not enabled");

  a_serial_alive: assert property (@(posedge clock) disable iff (reset)
    full_shutdown |-> serial_port_enable)
    else $error("serial port gated");

endmodule

`default_nettype wire
